// >>> pkg/ddc_path_pkg.sv
package ddc_path_pkg;
    // register indices and byte addresses
    localparam logic [3:0]  idx_serial_out = 4'h5;
    localparam logic [3:0]  idx_path_cfg   = 4'h6;
    localparam logic [3:0]  idx_sync_sel   = 4'hb;
    localparam logic [7:0]  adr_serial_out = 8'h14;
    localparam logic [7:0]  adr_path_cfg   = 8'h18;
    localparam logic [7:0]  adr_sync_sel   = 8'h2c;
    localparam logic [7:0]  adr_fifo_stat  = 8'h30;
    // serial output config fields
    localparam int          pos_clkdiv     = 12;
    localparam int          pos_wide       = 7;
    localparam int          pos_partner_q  = 6;
    localparam int          pos_fs_delay   = 0;
    // path config fields, then the sync select cic field
    localparam int          pos_mux_a      = 12;
    localparam int          pos_rnd_off    = 11;
    localparam int          pos_gain_embed = 10;
    localparam int          pos_rate       = 8;
    localparam int          pos_mux_b      = 4;
    localparam int          pos_real_only  = 3;
    localparam int          pos_cic_bypass = 2;
    localparam int          pos_dbl_tap    = 0;
    localparam int          pos_sync_cic   = 12;
    // reset values
    localparam logic [15:0] rst_serial_out = 16'h1001;
    localparam logic [15:0] rst_path_cfg   = 16'h0800;
    localparam logic [15:0] rst_sync_sel   = 16'h0000;
    // double-tap codes and tap counts, sample width and fifo depth
    localparam logic [1:0]  dbl_normal     = 2'h0;
    localparam logic [1:0]  dbl_secondary  = 2'h1;
    localparam logic [1:0]  dbl_main       = 2'h2;
    localparam int          taps_normal    = 64;
    localparam int          taps_double    = 128;
    localparam int          samp_w         = 16;
    localparam int          fifo_depth     = 16;

    typedef struct packed {
        logic [samp_w-1:0] i;
        logic [samp_w-1:0] q;
    } iq_t;

    typedef struct packed {
        logic [3:0] clk_div;
        logic       wide_pin;
        logic       partner_q;
        logic [1:0] fs_delay;
    } ser_cfg_t;

    typedef enum logic [2:0] {
        st_idle  = 3'b001,
        st_delay = 3'b010,
        st_shift = 3'b100
    } ser_state_t;
endpackage

// >>> core/iq_fifo.sv
`timescale 1ns/1ps
module iq_fifo
    import ddc_path_pkg::*;
#(
    parameter int WIDTH = 32,
    parameter int DEPTH = 16
)(
    input  wire logic             hclk,
    input  wire logic             hresetn,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data,
    output logic [$clog2(DEPTH):0] level
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wr_q;
    logic [AW-1:0]    rd_q;
    logic [AW:0]      cnt_q;
    wire              push = in_valid && in_ready;
    wire              pop  = out_valid && out_ready;

    // honest full and empty from the occupancy count
    assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign out_data  = mem_q[rd_q];
    assign level     = cnt_q;

    // storage write
    always_ff @(posedge hclk)
    begin
        if (push)
            mem_q[wr_q] <= in_data;
    end

    // pointers and count
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end
        else
        begin
            if (push)
                wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
            if (pop)
                rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

// >>> core/ddc_channel_path_control.sv
// The AHB-Lite register port was chosen for this implementation.
`timescale 1ns/1ps
module ddc_channel_path_control
    import ddc_path_pkg::*;
#(
    parameter int N_SRC  = 16,
    parameter int DEPTH  = fifo_depth
)(
    input  wire logic                     hclk,
    input  wire logic                     hresetn,
    input  wire logic                     hsel,
    input  wire logic [31:0]              haddr,
    input  wire logic [1:0]               htrans,
    input  wire logic                     hwrite,
    input  wire logic [2:0]               hsize,
    input  wire logic [31:0]              hwdata,
    input  wire logic                     hready,
    output logic      [31:0]              hrdata,
    output logic                          hreadyout,
    output logic                          hresp,
    input  wire logic                     umts_mode,
    input  wire logic [N_SRC*2*samp_w-1:0] mix_src,
    input  wire logic [samp_w-1:0]        rxin_a,
    input  wire logic [samp_w-1:0]        rxin_b,
    input  wire logic [7:0]               sync_sources,
    input  wire logic                     agc_valid,
    input  wire iq_t                      agc_full,
    input  wire logic [15:0]              agc_gain,
    input  wire iq_t                      partner_iq,
    output iq_t                           mixer_a,
    output iq_t                           mixer_b,
    output iq_t                           cfir_in,
    output logic                          cfir_sync,
    output logic                          cic_bypass,
    output logic                          cic_sync,
    output logic [2:0]                    rate_div_log2,
    output logic                          pfir_chain_out_en,
    output logic                          pfir_chain_in_en,
    output logic                          pfir_sum_add_en,
    output logic [7:0]                    pfir_max_taps,
    output logic [3:0]                    ser_i_pins,
    output logic [3:0]                    ser_q_pins,
    output logic                          ser_wide,
    output logic                          ser_bit_clk,
    output logic                          ser_frame_sync
);
    // register file
    logic [15:0] ser_cfg_q;
    logic [15:0] path_cfg_q;
    logic [15:0] sync_sel_q;
    // ahb address phase capture
    logic        wr_pend_q;
    logic [7:0]  adr_q;

    // ahb decode
    wire         take     = hsel && hready && htrans[1];
    wire         wr_ser   = wr_pend_q && (adr_q == adr_serial_out);
    wire         wr_path  = wr_pend_q && (adr_q == adr_path_cfg);
    wire         wr_sync  = wr_pend_q && (adr_q == adr_sync_sel);
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    // address phase register
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend_q <= 1'b0;
            adr_q     <= '0;
        end
        else
        begin
            wr_pend_q <= take && hwrite;
            if (take)
                adr_q <= haddr[7:0];
        end
    end

    // config register writes land in the data phase
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ser_cfg_q  <= rst_serial_out;
            path_cfg_q <= rst_path_cfg;
            sync_sel_q <= rst_sync_sel;
        end
        else
        begin
            if (wr_ser)
                ser_cfg_q <= hwdata[15:0];
            if (wr_path)
                path_cfg_q <= hwdata[15:0];
            if (wr_sync)
                sync_sel_q <= hwdata[15:0];
        end
    end

    // field extraction
    ser_cfg_t    scfg;
    wire  [3:0]  sel_a     = path_cfg_q[pos_mux_a +: 4];
    wire  [3:0]  sel_b     = path_cfg_q[pos_mux_b +: 4];
    wire         rnd_off   = path_cfg_q[pos_rnd_off];
    wire         gain_emb  = path_cfg_q[pos_gain_embed];
    wire  [1:0]  rate      = path_cfg_q[pos_rate +: 2];
    wire         real_only = path_cfg_q[pos_real_only];
    wire  [1:0]  dbl       = path_cfg_q[pos_dbl_tap +: 2];
    wire  [2:0]  sync_cic  = sync_sel_q[pos_sync_cic +: 3];
    assign scfg = ser_cfg_t'({ser_cfg_q[pos_clkdiv +: 4], ser_cfg_q[pos_wide],
                              ser_cfg_q[pos_partner_q], ser_cfg_q[pos_fs_delay +: 2]});

    // pick one I/Q pair from the source bus
    function automatic iq_t pick_src(input logic [N_SRC*2*samp_w-1:0] bus, input logic [3:0] s, input logic ro);
        iq_t v;
        v = iq_t'(bus[s*2*samp_w +: 2*samp_w]);
        if (ro)
            v.q = '0;
        return v;
    endfunction

    // mixer inputs, with Q held at zero in real-only mode
    assign mixer_a = pick_src(mix_src, sel_a, real_only);
    assign mixer_b = pick_src(mix_src, sel_b, real_only);

    // the raw ports always feed the cfir; cic bypass gates the cfir sync
    assign cic_bypass = path_cfg_q[pos_cic_bypass];
    assign cfir_in    = '{i: rxin_a, q: rxin_b};
    assign cfir_sync  = cic_bypass && rxin_a[0];
    assign cic_sync   = sync_sources[sync_cic];
    assign rate_div_log2 = {1'b0, rate};

    // double tap chaining controls
    assign pfir_chain_out_en = (dbl == dbl_main);
    assign pfir_sum_add_en   = (dbl == dbl_main);
    assign pfir_chain_in_en  = (dbl == dbl_secondary);
    assign pfir_max_taps     = (dbl == dbl_normal) ? 8'(taps_normal) : 8'(taps_double);

    // agc output shaping: rounding and gain embed
    iq_t         agc_shaped;
    wire  [15:0] rnd_i = agc_full.i + {15'h0000, ~rnd_off};
    wire  [15:0] rnd_q = agc_full.q + {15'h0000, ~rnd_off};
    assign agc_shaped.i = gain_emb ? {rnd_i[15:1], agc_gain[15]} : rnd_i;
    assign agc_shaped.q = gain_emb ? {rnd_q[15:1], agc_gain[14]} : rnd_q;

    // sample buffer between agc and the serializer
    logic        f_ready;
    logic        f_valid;
    iq_t         f_data;
    logic        f_pop;
    logic [$clog2(DEPTH):0] f_level;
    iq_fifo #(.WIDTH(2*samp_w), .DEPTH(DEPTH)) u_fifo (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .in_valid  (agc_valid),
        .in_ready  (f_ready),
        .in_data   (agc_shaped),
        .out_valid (f_valid),
        .out_ready (f_pop),
        .out_data  (f_data),
        .level     (f_level)
    );

    // read mux
    wire  [15:0] rd_mux = (adr_q == adr_serial_out) ? ser_cfg_q :
                          (adr_q == adr_path_cfg)   ? path_cfg_q :
                          (adr_q == adr_sync_sel)   ? sync_sel_q :
                          (adr_q == adr_fifo_stat)  ? {f_ready, f_valid, 9'h000, 5'(f_level)} : 16'h0000;
    assign hrdata = {16'h0000, rd_mux};

    // serializer state
    ser_state_t  st_q;
    logic [3:0]  div_q;
    logic [1:0]  dly_q;
    logic [4:0]  bit_q;
    logic        bclk_q;
    logic        fs_q;
    logic [15:0] sh_i_q;
    logic [15:0] sh_q_q;
    logic [3:0]  oi_q;
    logic [3:0]  oq_q;
    wire         tick     = (div_q == scfg.clk_div);
    wire  [4:0]  half_per = (5'(scfg.clk_div) + 5'h01) >> 1; // bit clock high for half the period, rounded down, from one hclk into the bit
    wire         wide     = umts_mode && scfg.wide_pin;
    wire  [4:0]  lanes    = wide ? 5'd4 : 5'd2;
    wire  [4:0]  last_bit = 5'(samp_w) - lanes;
    wire  [15:0] q_src    = scfg.partner_q ? partner_iq.q : f_data.q;
    assign f_pop    = tick && (st_q == st_idle) && f_valid;
    assign ser_wide = wide;

    // bit clock divider
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            div_q  <= '0;
            bclk_q <= 1'b0;
        end
        else
        begin
            div_q  <= tick ? 4'h0 : div_q + 4'h1;
            bclk_q <= ({1'b0, div_q} < half_per); // rises the cycle after a tick, one hclk into the bit
        end
    end

    // frame state machine: sync, delay, shift
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            st_q   <= st_idle;
            dly_q  <= '0;
            bit_q  <= '0;
            fs_q   <= 1'b0;
            sh_i_q <= '0;
            sh_q_q <= '0;
            oi_q   <= '0;
            oq_q   <= '0;
        end
        else if (tick)
        begin
            fs_q <= 1'b0;
            case (st_q)
                st_idle:
                begin
                    if (f_valid)
                    begin
                        sh_i_q <= f_data.i;
                        sh_q_q <= q_src;
                        fs_q   <= 1'b1;
                        dly_q  <= scfg.fs_delay;
                        bit_q  <= '0;
                        st_q   <= (scfg.fs_delay == 2'h0) ? st_shift : st_delay;
                    end
                end
                st_delay:
                begin
                    dly_q <= dly_q - 2'h1;
                    if (dly_q == 2'h1)
                        st_q <= st_shift;
                end
                st_shift:
                begin
                    // wide pair: I on these pins, Q goes out on the neighbour
                    if (wide)
                    begin
                        oi_q <= sh_i_q[15:12];
                        oq_q <= sh_q_q[15:12];
                    end
                    else
                    begin
                        oi_q <= {2'b00, sh_i_q[15:14]};
                        oq_q <= {2'b00, sh_q_q[15:14]};
                    end
                    sh_i_q <= wide ? {sh_i_q[11:0], 4'h0} : {sh_i_q[13:0], 2'b00};
                    sh_q_q <= wide ? {sh_q_q[11:0], 4'h0} : {sh_q_q[13:0], 2'b00};
                    bit_q  <= bit_q + lanes;
                    if (bit_q == last_bit)
                        st_q <= st_idle;
                end
                default:
                    st_q <= st_idle;
            endcase
        end
    end

    assign ser_i_pins     = oi_q;
    assign ser_q_pins     = oq_q;
    // full rate leaves no room for a divided clock, so the inverted clock marks mid-bit
    assign ser_bit_clk    = (scfg.clk_div == 4'h0) ? ~hclk : bclk_q;
    assign ser_frame_sync = fs_q;
endmodule

// >>> verif/path_checker.sv
`timescale 1ns/1ps
module path_checker
    import ddc_path_pkg::*;
#(
    parameter int N_SRC = 16
)(
    input wire logic                     hclk,
    input wire logic                     hresetn,
    input wire logic                     hsel,
    input wire logic [31:0]              haddr,
    input wire logic [1:0]               htrans,
    input wire logic                     hwrite,
    input wire logic [31:0]              hwdata,
    input wire logic                     hready,
    input wire logic                     umts_mode,
    input wire logic [N_SRC*2*samp_w-1:0] mix_src,
    input wire logic [samp_w-1:0]        rxin_a,
    input wire logic [samp_w-1:0]        rxin_b,
    input wire logic [7:0]               sync_sources,
    input wire iq_t                      mixer_a,
    input wire iq_t                      mixer_b,
    input wire iq_t                      cfir_in,
    input wire logic                     cfir_sync,
    input wire logic                     cic_bypass,
    input wire logic                     cic_sync,
    input wire logic [2:0]               rate_div_log2,
    input wire logic                     pfir_chain_out_en,
    input wire logic                     pfir_chain_in_en,
    input wire logic                     pfir_sum_add_en,
    input wire logic [7:0]               pfir_max_taps,
    input wire logic                     ser_wide
);
    logic        wen_q;
    logic [7:0]  wa_q;
    logic [15:0] pc_q;
    logic [15:0] ss_q;
    logic [15:0] sc_q;
    // shadow copies of the path, sync and serial output registers
    always_ff @(posedge hclk or negedge hresetn)
        if (!hresetn)
        begin
            wen_q <= 1'b0;
            wa_q  <= 8'h00;
            pc_q  <= rst_path_cfg;
            ss_q  <= rst_sync_sel;
            sc_q  <= rst_serial_out;
        end
        else
        begin
            wen_q <= hsel & hready & htrans[1] & hwrite;
            wa_q  <= haddr[7:0];
            if (wen_q && wa_q == adr_path_cfg)
                pc_q <= hwdata[15:0];
            if (wen_q && wa_q == adr_sync_sel)
                ss_q <= hwdata[15:0];
            if (wen_q && wa_q == adr_serial_out)
                sc_q <= hwdata[15:0];
        end
    // expected mixer inputs
    wire iq_t src_a = mix_src[pc_q[pos_mux_a +: 4]*32 +: 32];
    wire iq_t src_b = mix_src[pc_q[pos_mux_b +: 4]*32 +: 32];
    wire      ronly = pc_q[pos_real_only];
    wire      main  = pc_q[1:0] == dbl_main;
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    sequence bypass_rise;
        cic_bypass && $rose(rxin_a[0]);
    endsequence
    sequence chain_main;
        pfir_chain_out_en && pfir_sum_add_en && !pfir_chain_in_en;
    endsequence
    mux_select_a: assert property (mixer_a == {src_a.i, ronly ? 16'h0000 : src_a.q})
        else $error("mixer a input wrong");
    mux_select_b_a: assert property (mixer_b == {src_b.i, ronly ? 16'h0000 : src_b.q})
        else $error("mixer b input wrong");
    rate_field_a: assert property (rate_div_log2 == {1'b0, pc_q[pos_rate +: 2]})
        else $error("rate output wrong");
    bypass_route_a: assert property (cic_bypass == pc_q[pos_cic_bypass] && (cic_bypass -> cfir_in == {rxin_a, rxin_b}))
        else $error("bypass routing wrong");
    bypass_sync_a: assert property (bypass_rise |-> cfir_sync)
        else $error("bypass sync missing");
    chain_main_a: assert property (main |-> chain_main)
        else $error("main chaining wrong");
    chain_sec_a: assert property (pfir_chain_in_en == (pc_q[1:0] == dbl_secondary))
        else $error("secondary chaining wrong");
    tap_limit_a: assert property (!pfir_chain_in_en |-> pfir_max_taps == (main ? 8'd128 : 8'd64))
        else $error("tap limit wrong");
    cic_sync_a: assert property (cic_sync == sync_sources[ss_q[pos_sync_cic +: 3]])
        else $error("cic sync source wrong");
    wide_mode_a: assert property (ser_wide == (umts_mode && sc_q[pos_wide]))
        else $error("wide mode select wrong");
endmodule

bind ddc_channel_path_control path_checker #(.N_SRC(N_SRC)) chk (.*);

// >>> verif/serial_sink.sv
`timescale 1ns/1ps
module serial_sink
(
    input wire logic        ser_bit_clk,
    input wire logic        hresetn,
    input wire logic        ser_frame_sync,
    input wire logic [3:0]  ser_i_pins,
    input wire logic [3:0]  ser_q_pins,
    input wire logic        wide,
    input wire logic [1:0]  delay,
    output logic     [15:0] i_word,
    output logic     [15:0] q_word,
    output int              frames
);
    logic       on_q;
    logic [4:0] n_q;
    // last tick of a frame: delay then four or eight data ticks
    wire  [4:0] last = {3'b000, delay} + (wide ? 5'd4 : 5'd8);
    // gather lanes msb first after each frame sync
    always_ff @(posedge ser_bit_clk or negedge hresetn)
        if (!hresetn)
        begin
            on_q   <= 1'b0;
            n_q    <= 5'd0;
            frames <= 0;
        end
        else if (ser_frame_sync && !on_q)
        begin
            on_q <= 1'b1;
            n_q  <= 5'd0;
        end
        else if (on_q)
        begin
            n_q    <= n_q + 5'd1;
            i_word <= wide ? {i_word[11:0], ser_i_pins} : {i_word[13:0], ser_i_pins[1:0]};
            q_word <= wide ? {q_word[11:0], ser_q_pins} : {q_word[13:0], ser_q_pins[1:0]};
            if (n_q + 5'd1 == last)
            begin
                on_q   <= 1'b0;
                frames <= frames + 1;
            end
        end
endmodule

// >>> verif/testbench.sv
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin err_count++; $display("ERROR %0t: got %h exp %h", $time, g, e); end end
module testbench
    import ddc_path_pkg::*;
;
    logic         hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, umts_mode = 0, agc_valid = 0, wd = 0;
    logic [31:0]  haddr = 0, hwdata = 0, hrdata, rd_s;
    logic [1:0]   htrans = 0, dl = 2'h1;
    logic [2:0]   hsize = 3'h2, rate_div_log2;
    logic [511:0] mix_src;
    logic [15:0]  rxin_a = 0, rxin_b = 0, agc_gain = 0, i_word, q_word, v;
    logic [7:0]   sync_sources = 0, pfir_max_taps;
    iq_t          agc_full = 0, partner_iq = 0, mixer_a, mixer_b, cfir_in;
    logic         hreadyout, hresp, cfir_sync, cic_bypass, cic_sync, pfir_chain_out_en, pfir_chain_in_en, rdy_s;
    logic         pfir_sum_add_en, ser_wide, ser_bit_clk, ser_frame_sync;
    logic [3:0]   ser_i_pins, ser_q_pins;
    int           frames, err_count = 0, n_compared = 0;

    ddc_channel_path_control dut (.hready(hreadyout), .*);
    serial_sink sink (.wide(wd), .delay(dl), .*);

    always #25 hclk = ~hclk;
    // bus answer as seen at each rising edge
    always @(posedge hclk)
    begin
        rdy_s <= hreadyout;
        rd_s  <= hrdata;
    end

    task automatic complete_run;
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // one single-word transfer; read data lands in v
    task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] d);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge hclk) #1; while (rdy_s !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {16'h0, d};
        do @(posedge hclk) #1; while (rdy_s !== 1'b1);
        v = rd_s[15:0];
    endtask

    task automatic t_regs;
        bus(0, adr_serial_out, 0);
        `CHK(v, rst_serial_out)
        bus(0, adr_path_cfg, 0);
        `CHK(v, rst_path_cfg)
        bus(0, adr_sync_sel, 0);
        `CHK(v, rst_sync_sel)
        bus(1, 8'h40, 16'hffff);
        bus(0, 8'h40, 0);
        `CHK(v, 16'h0000)
        `CHK({hreadyout, hresp}, 2'b10)
    endtask

    task automatic t_mux;
        for (int s = 0; s < 16; s++)
        begin
            bus(1, adr_path_cfg, 16'(s << pos_mux_a | (15 - s) << pos_mux_b | (s % 2) << pos_real_only));
            `CHK(mixer_a, {16'h1000 + 16'(s), (s % 2) ? 16'h0 : 16'h2000 + 16'(s)})
            `CHK(mixer_b, {16'h100f - 16'(s), (s % 2) ? 16'h0 : 16'h200f - 16'(s)})
        end
    endtask

    task automatic t_rate;
        for (int r = 0; r < 4; r++)
        begin
            bus(1, adr_path_cfg, 16'(r << pos_rate));
            `CHK(rate_div_log2, 3'(r))
        end
        bus(1, adr_path_cfg, 16'(1 << pos_rate));
    endtask

    task automatic t_bypass;
        rxin_a <= 16'h1234;
        rxin_b <= 16'h8765;
        bus(1, adr_path_cfg, 16'(1 << pos_cic_bypass));
        `CHK(cfir_in, {16'h1234, 16'h8765})
        `CHK(cfir_sync, 1'b0)
        rxin_a <= 16'h1235;
        @(posedge hclk) #1;
        `CHK({cic_bypass, cfir_sync}, 2'b11)
    endtask

    task automatic t_dbl;
        logic [1:0] c[3] = '{dbl_normal, dbl_main, dbl_secondary};
        foreach (c[k])
        begin
            bus(1, adr_path_cfg, {14'h0, c[k]});
            `CHK({pfir_chain_out_en, pfir_sum_add_en, pfir_chain_in_en}, {{2{c[k] == 2'h2}}, c[k] == 2'h1})
            if (c[k] != dbl_secondary)
                `CHK(pfir_max_taps, c[k] == dbl_main ? 8'd128 : 8'd64)
        end
    endtask

    task automatic t_sync;
        for (int k = 0; k < 8; k++)
        begin
            sync_sources <= 8'(1 << k);
            bus(1, adr_sync_sel, 16'(k << pos_sync_cic));
            `CHK(cic_sync, 1'b1)
        end
    endtask

    // push one sample and judge the frame the sink gathers
    task automatic frame(input logic [15:0] ei, input logic [15:0] eq);
        int f0 = frames;
        agc_full <= {16'ha5c3, 16'h3c5a};
        agc_valid <= 1'b1;
        @(posedge hclk) #1;
        agc_valid <= 1'b0;
        for (int n = 0; n < 400 && frames == f0; n++) @(posedge hclk) #1;
        `CHK(i_word, ei)
        `CHK(q_word, eq)
    endtask

    task automatic t_serial;
        dl = 2'h2;
        bus(1, adr_serial_out, 16'h1002);
        bus(1, adr_path_cfg, rst_path_cfg);
        frame(16'ha5c3, 16'h3c5a);
        umts_mode <= 1'b1;
        partner_iq <= {16'h0, 16'h7e81};
        wd = 1'b1;
        dl = 2'h0;
        bus(1, adr_serial_out, 16'h10c0);
        `CHK(ser_wide, 1'b1)
        frame(16'ha5c3, 16'h7e81);
        umts_mode <= 1'b0;
        wd = 1'b0;
        agc_gain <= 16'h8000;
        bus(1, adr_serial_out, 16'h1000);
        bus(1, adr_path_cfg, 16'(1 << pos_gain_embed));
        frame(16'ha5c5, 16'h3c5a);
    endtask

    // fill the fifo past full with a slow bit clock, then drain
    task automatic t_fifo;
        bus(1, adr_serial_out, 16'hf000);
        agc_valid <= 1'b1;
        repeat (20) @(posedge hclk) #1;
        agc_valid <= 1'b0;
        bus(0, adr_fifo_stat, 0);
        `CHK(v, 16'h4010)
        repeat (4000) @(posedge hclk);
        bus(0, adr_fifo_stat, 0);
        `CHK(v, 16'h8000)
    endtask

    initial
    begin
        for (int s = 0; s < 16; s++)
            mix_src[s*32 +: 32] = {16'h1000 + 16'(s), 16'h2000 + 16'(s)};
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk) #1;
        t_regs;
        t_mux;
        t_rate;
        t_bypass;
        t_dbl;
        t_sync;
        t_serial;
        t_fifo;
        complete_run;
    end

    // hang guard well past the expected run
    initial
    begin
        #2000000;
        err_count++;
        complete_run;
    end
endmodule
